// File: design/sink_blink_timer.sv
// Function
// - Enable bits 7..0 switch sinks eight..one; 1 on, 0 off.
// - With off time active, sink stays on for the on-time field bits 7:4.
// - On time is code times 0.05 s, zero to 0.75 s, then off.
// - Sink five off-time field bits 1:0: off, 0.6, 1.2, 1.8 s.
// - Off-time code 00 keeps an enabled sink on steadily.
// - Nonzero off code: on for on time, off for off time, repeat.
// - Zero on time with off time active: no hold at full level.
// - Ninth sink enable sits at bit 2 of a separate control register.
`timescale 1ns/10ps
`default_nettype none
module sink_blink_timer
    import sink_blink_pkg::*;
#(
    parameter int tick_cycles = tick_cycles_default
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [8:0] sink_drive
);
    // ****************************************
    // Register slave
    // ****************************************
    logic [7:0] enable_low_reg, enable_high_reg, timing_reg;
    logic [7:0] awaddr_reg;
    logic aw_held_reg, w_held_reg;
    logic [31:0] wdata_reg;
    logic wstrb0_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire [7:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    wire wr_lane0 = w_held_reg ? wstrb0_reg : s_axi_wstrb[0];
    wire wr_go = (aw_held_reg || aw_fire) && (w_held_reg || w_fire);
    wire wr_low = wr_addr == enable_low_offset;
    wire wr_high = wr_addr == enable_high_offset;
    wire wr_time = wr_addr == timing_1_offset;
    wire wr_hit = wr_low || wr_high || wr_time || wr_addr == status_offset;
    wire wr_en = wr_go && wr_lane0;

    assign s_axi_arready = !rvalid_reg;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire rd_hit = s_axi_araddr == enable_low_offset || s_axi_araddr == enable_high_offset
        || s_axi_araddr == timing_1_offset || s_axi_araddr == status_offset;
    wire [7:0] rd_byte = (s_axi_araddr == enable_low_offset) ? enable_low_reg :
        (s_axi_araddr == enable_high_offset) ? enable_high_reg :
        (s_axi_araddr == timing_1_offset) ? (timing_reg & timing_rw_mask) :
        (s_axi_araddr == status_offset) ? sink_drive[7:0] : 8'h00;
    wire rd_bit8 = s_axi_araddr == status_offset && sink_drive[8];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
        end else begin
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? 2'b00 : 2'b10;
            end else begin
                if (aw_fire) begin
                    aw_held_reg <= 1'b1;
                    awaddr_reg <= s_axi_awaddr;
                end
                if (w_fire) begin
                    w_held_reg <= 1'b1;
                    wdata_reg <= s_axi_wdata;
                    wstrb0_reg <= s_axi_wstrb[0];
                end
                if (bvalid_reg && s_axi_bready) begin
                    bvalid_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_low_reg <= enable_low_reset;
            enable_high_reg <= enable_high_reset;
            timing_reg <= timing_1_reset;
        end else if (wr_en) begin
            if (wr_low) begin
                enable_low_reg <= wr_data[7:0];
            end
            if (wr_high) begin
                enable_high_reg <= wr_data[7:0] & (8'h01 << nine_enable_bit);
            end
            if (wr_time) begin
                timing_reg <= wr_data[7:0] & timing_rw_mask;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= 2'b00;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {23'h00_0000, rd_bit8, rd_byte};
            rresp_reg <= rd_hit ? 2'b00 : 2'b10;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ****************************************
    // Shared timebase
    // ****************************************
    logic [31:0] tick_count_reg;
    wire tick_now = tick_count_reg == 32'(tick_cycles - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_count_reg <= 32'h0000_0000;
        end else begin
            tick_count_reg <= tick_now ? 32'h0000_0000 : tick_count_reg + 32'h0000_0001;
        end
    end

    // ****************************************
    // Sink channels
    // ****************************************
    // Only sink five owns an off-time field here; other sinks run steady.
    wire [8:0] sink_enable = {enable_high_reg[nine_enable_bit], enable_low_reg};
    wire [3:0] on_code = timing_reg[on_field_lsb +: 4];
    wire [1:0] five_off = timing_reg[off_field_lsb +: 2];
    genvar i;
    generate
        for (i = 0; i < sink_count; i++) begin : g_sink
            sink_blink_channel u_channel (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(tick_now),
                .enable(sink_enable[i]),
                .on_code(on_code),
                .off_code((i == five_index) ? five_off : 2'b00),
                .sink_on(sink_drive[i])
            );
        end
    endgenerate

    // ****************************************
    // Bus and register checks
    // ****************************************
    // A write completes in two steps: both channels in, then the answer blocks new requests
    sequence s_write_taken;
        wr_go;
    endsequence
    sequence s_write_answer;
        s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_bresp_after_write;
        @(posedge aclk) disable iff (!aresetn) s_write_taken |=> s_write_answer;
    endproperty
    a_bresp_after_write: assert property (p_bresp_after_write) else $error("write not answered");
    property p_write_error;
        @(posedge aclk) disable iff (!aresetn) wr_go && !wr_hit |=> s_axi_bresp == 2'b10;
    endproperty
    a_write_error: assert property (p_write_error) else $error("unmapped write not refused");
    // A cleared byte lane 0 strobe must leave every register alone, not just the addressed one
    property p_masked_write;
        @(posedge aclk) disable iff (!aresetn)
            wr_go && !wr_lane0 |=> $stable(timing_reg) && $stable(enable_low_reg) && $stable(enable_high_reg);
    endproperty
    a_masked_write: assert property (p_masked_write) else $error("masked write changed a register");
    property p_read_answer;
        @(posedge aclk) disable iff (!aresetn) s_read_taken |=> s_axi_rvalid && s_axi_rdata[31:9] == 23'h00_0000;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_read_error;
        @(posedge aclk) disable iff (!aresetn) ar_fire && !rd_hit |=> s_axi_rresp == 2'b10;
    endproperty
    a_read_error: assert property (p_read_error) else $error("unmapped read not refused");
    property p_timing_write;
        @(posedge aclk) disable iff (!aresetn)
            wr_en && wr_time |=> timing_reg == ($past(wr_data[7:0]) & timing_rw_mask);
    endproperty
    a_timing_write: assert property (p_timing_write) else $error("timing write lost");
    property p_reserved_zero;
        @(posedge aclk) disable iff (!aresetn) timing_reg[3:2] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved timing bits set");
    property p_enable_write;
        @(posedge aclk) disable iff (!aresetn) wr_en && wr_low |=> enable_low_reg == $past(wr_data[7:0]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");
    property p_nine_bit;
        @(posedge aclk) disable iff (!aresetn) wr_en && wr_high |=> enable_high_reg[2] == $past(wr_data[2]);
    endproperty
    a_nine_bit: assert property (p_nine_bit) else $error("ninth enable wrong");
endmodule
`default_nettype wire

// File: common/sink_blink_pkg.sv
package sink_blink_pkg;
    // ****************************************
    // Register map
    // ****************************************
    // Registers are numbered by word index; the bus byte address is four times the index
    localparam logic [5:0] timing_1_index = 6'h1c;
    localparam logic [5:0] enable_low_index = 6'h1b;
    localparam logic [5:0] enable_high_index = 6'h1a;
    localparam logic [5:0] status_index = 6'h20;
    localparam logic [7:0] timing_1_offset = {timing_1_index, 2'b00};
    localparam logic [7:0] enable_low_offset = {enable_low_index, 2'b00};
    localparam logic [7:0] enable_high_offset = {enable_high_index, 2'b00};
    localparam logic [7:0] status_offset = {status_index, 2'b00};
    localparam logic [7:0] timing_rw_mask = 8'hf3;
    localparam logic [7:0] enable_low_reset = 8'h00;
    localparam logic [7:0] enable_high_reset = 8'h00;
    localparam logic [7:0] timing_1_reset = 8'h00;
    localparam int nine_enable_bit = 2;
    localparam int on_field_lsb = 4;
    localparam int off_field_lsb = 0;
    localparam int sink_count = 9;
    localparam int five_index = 4;
    // ****************************************
    // Timing
    // ****************************************
    localparam int clock_mhz = 200;
    localparam int on_step_ms = 50;
    localparam int off_step_ms = 600;
    localparam int tick_ms = 1;
    localparam int tick_cycles_default = tick_ms * clock_mhz * 1000;
    localparam logic [15:0] on_step_ticks = 16'(on_step_ms / tick_ms);
    localparam logic [15:0] off_step_ticks = 16'(off_step_ms / tick_ms);
    typedef enum logic [1:0] {blink_idle, blink_on, blink_off} blink_state_t;
endpackage

// File: design/sink_blink_channel.sv
`timescale 1ns/10ps
`default_nettype none
module sink_blink_channel
    import sink_blink_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic enable,
    input wire logic [3:0] on_code,
    input wire logic [1:0] off_code,
    output logic sink_on
);
    blink_state_t state_reg, state_next;
    logic [15:0] count_reg, count_next;
    wire [15:0] on_ticks = 16'(on_code * on_step_ticks);
    wire [15:0] off_ticks = 16'(off_code * off_step_ticks);
    wire expired = (count_reg == 16'h0000) || (tick && count_reg == 16'h0001);
    wire [15:0] count_dec = (tick && count_reg != 16'h0000) ? count_reg - 16'h0001 : count_reg;

    always_comb begin
        state_next = state_reg;
        count_next = count_dec;
        case (state_reg)
            blink_idle: begin
                if (enable) begin
                    state_next = blink_on;
                    count_next = on_ticks;
                end
            end
            blink_on: begin
                if (!enable) begin
                    state_next = blink_idle;
                end else if (off_code != 2'b00 && expired) begin
                    state_next = blink_off;
                    count_next = off_ticks;
                end else if (off_code == 2'b00) begin
                    count_next = on_ticks;
                end
            end
            blink_off: begin
                if (!enable) begin
                    state_next = blink_idle;
                end else if (off_code == 2'b00 || expired) begin
                    state_next = blink_on;
                    count_next = on_ticks;
                end
            end
            default: state_next = blink_idle;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= blink_idle;
            count_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    assign sink_on = (state_reg == blink_on) && enable;

    property p_off_when_disabled;
        @(posedge aclk) disable iff (!aresetn) !enable |-> !sink_on ##1 state_reg == blink_idle;
    endproperty
    a_off_when_disabled: assert property (p_off_when_disabled) else $error("sink on while disabled");
    property p_steady;
        @(posedge aclk) disable iff (!aresetn)
            enable && off_code == 2'b00 && $past(enable) && $past(off_code) == 2'b00 && $past(enable, 2) |-> sink_on;
    endproperty
    a_steady: assert property (p_steady) else $error("steady sink dropped");
    property p_off_has_code;
        @(posedge aclk) disable iff (!aresetn) state_reg == blink_off |-> $past(off_code) != 2'b00;
    endproperty
    a_off_has_code: assert property (p_off_has_code) else $error("off phase without off code");
    property p_no_early_off;
        @(posedge aclk) disable iff (!aresetn)
            state_reg == blink_on && count_reg > 16'h0001 && enable |=> state_reg == blink_on;
    endproperty
    a_no_early_off: assert property (p_no_early_off) else $error("on phase ended early");
    property p_zero_on;
        @(posedge aclk) disable iff (!aresetn)
            state_reg == blink_on && on_code == 4'h0 && $past(on_code) == 4'h0 && enable && off_code != 2'b00
            && $past(state_reg) != blink_on |=> state_reg == blink_off;
    endproperty
    a_zero_on: assert property (p_zero_on) else $error("zero on time held");
endmodule
`default_nettype wire

// File: verif/led_sink_blink_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module led_sink_blink_timer_test;
    import sink_blink_pkg::*;
    // ****************************************
    // Bench signals
    // ****************************************
    // A short tick keeps the longest off interval to a few thousand cycles
    localparam int tc = 2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [8:0] sink_drive;
    int fail_count = 0;
    int checks = 0;
    always #2.5 aclk = ~aclk;
    sink_blink_timer #(.tick_cycles(tc)) sink_blink_timer_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sink_drive(sink_drive));
    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic close_out;
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic give_up;
        fail_count++;
        close_out();
    endtask
    // Ready is sampled at the falling edge; inputs only move at rising edges, so it equals the edge value
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        bit aw, w, b;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 100) give_up();
        `CHK(r, er)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        bit ar, v;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (v) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 100) give_up();
        `CHK(r, er)
        if (er === 2'b00) `CHK(d, ed)
    endtask
    // Length of the next full interval at level lv on one sink
    task automatic span(input int b, input logic lv, output int n);
        int k, j;
        @(negedge aclk);
        for (k = 0; k < 5000 && sink_drive[b] === lv; k++) @(negedge aclk);
        for (j = 0; j < 5000 && sink_drive[b] !== lv; j++) @(negedge aclk);
        for (n = 0; n < 5000 && sink_drive[b] === lv; n++) @(negedge aclk);
        if (n == 5000 || k == 5000 || j == 5000) give_up();
    endtask
    function automatic logic near(input int a, input int e);
        return (a >= e - 2 * tc - 2) && (a <= e + 2 * tc + 2);
    endfunction
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_map;
        rd(timing_1_offset, 32'h0000_0000, 2'b00);
        rd(enable_low_offset, 32'h0000_0000, 2'b00);
        rd(enable_high_offset, 32'h0000_0000, 2'b00);
        wr(timing_1_offset, 32'hffff_ffff, 2'b00);
        rd(timing_1_offset, 32'h0000_00f3, 2'b00);
        s_axi_wstrb <= 4'h0;
        wr(timing_1_offset, 32'h0000_0000, 2'b00);
        s_axi_wstrb <= 4'hf;
        rd(timing_1_offset, 32'h0000_00f3, 2'b00);
        wr(8'h40, 32'h0000_00ff, 2'b10);
        rd(8'h40, 32'h0000_0000, 2'b10);
        wr(timing_1_offset, 32'h0000_0000, 2'b00);
    endtask
    task automatic t_enables;
        for (int i = 0; i < 8; i++) begin
            wr(enable_low_offset, 32'(1 << i), 2'b00);
            repeat (3) @(posedge aclk);
            `CHK(sink_drive, 9'(1 << i))
            rd(status_offset, 32'(1 << i), 2'b00);
        end
        wr(enable_low_offset, 32'h0000_0000, 2'b00);
        wr(enable_high_offset, 32'h0000_0004, 2'b00);
        repeat (3) @(posedge aclk);
        `CHK(sink_drive, 9'h100)
        wr(enable_high_offset, 32'h0000_0000, 2'b00);
        repeat (3) @(posedge aclk);
        `CHK(sink_drive, 9'h000)
    endtask
    task automatic t_blink(input logic [3:0] c, input logic [1:0] o);
        int n;
        wr(timing_1_offset, {24'h0, c, 2'b00, o}, 2'b00);
        wr(enable_low_offset, 32'h0000_0011, 2'b00);
        span(4, 1'b0, n);
        `CHK(near(n, o * 600 * tc), 1'b1)
        span(4, 1'b1, n);
        `CHK(near(n, c * 50 * tc), 1'b1)
        `CHK(sink_drive[0], 1'b1)
        wr(enable_low_offset, 32'h0000_0000, 2'b00);
    endtask
    task automatic t_steady;
        int bad;
        bad = 0;
        wr(timing_1_offset, 32'h0000_0010, 2'b00);
        wr(enable_low_offset, 32'h0000_0010, 2'b00);
        repeat (3) @(negedge aclk);
        for (int k = 0; k < 2000; k++) begin
            @(negedge aclk);
            if (sink_drive[4] !== 1'b1) bad++;
        end
        `CHK(bad, 0)
        wr(enable_low_offset, 32'h0000_0000, 2'b00);
    endtask
    task automatic t_zero_on;
        int n;
        wr(timing_1_offset, 32'h0000_0001, 2'b00);
        wr(enable_low_offset, 32'h0000_0010, 2'b00);
        span(4, 1'b0, n);
        span(4, 1'b1, n);
        `CHK(n <= 2, 1'b1)
        wr(enable_low_offset, 32'h0000_0000, 2'b00);
    endtask
    // Reset in mid-run while the low sinks are on and sink five blinks: everything returns to its idle state
    task automatic t_mid_reset;
        wr(enable_low_offset, 32'h0000_00ff, 2'b00);
        wr(timing_1_offset, 32'h0000_0052, 2'b00);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        `CHK(sink_drive, 9'h000)
        rd(enable_low_offset, 32'h0000_0000, 2'b00);
        rd(timing_1_offset, 32'h0000_0000, 2'b00);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_map();
        t_enables();
        t_blink(4'h1, 2'b01);
        t_blink(4'hf, 2'b10);
        t_blink(4'h3, 2'b11);
        t_steady();
        t_zero_on();
        t_mid_reset();
        close_out();
    end
endmodule
`default_nettype wire
